// *** cpu_backplane_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module cpu_backplane_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Requests from the panel
    input wire logic clear_request_n,
    input wire logic wait_request_n,
    input wire logic dma_out_request_n,
    input wire logic utility_start_request,
    // Backplane and observation
    output panel_pkg::backplane_type backplane,
    output logic [15:0] cycle_count,
    output logic [15:0] dma_count,
    output logic [15:0] cur_addr,
    output logic [1:0] cur_state
);
    localparam logic [15:0] EXEC_TAB [4] = '{16'h83ff, 16'h8400, 16'h87ff, 16'h8800};
    logic [3:0] phase_q;
    logic [1:0] st_q;
    logic [15:0] pc_q;
    logic [15:0] dma_ptr_q;
    logic init_q;
    logic idle_q;
    logic util_q;
    logic [7:0] data_w;

    // The only idle opcode sits at 0006 and is followed by no-ops.
    function automatic logic [7:0] mem_byte(input logic [15:0] a);
        return (a == 16'h0006) ? panel_pkg::IDLE_OPCODE : {4'hb, ~a[3:0]};
    endfunction : mem_byte

    assign cur_state = init_q ? panel_pkg::STATE_EXECUTE : st_q;
    always_comb
    begin
        case (st_q)
            panel_pkg::STATE_FETCH: cur_addr = pc_q;
            panel_pkg::STATE_DMA: cur_addr = dma_ptr_q;
            default: cur_addr = idle_q ? pc_q : EXEC_TAB[pc_q[1:0]];
        endcase
    end
    assign data_w = (st_q != panel_pkg::STATE_EXECUTE) ? mem_byte(cur_addr) :
        idle_q ? panel_pkg::IDLE_OPCODE : {cur_addr[3:0], ~cur_addr[3:0]};
    assign backplane.first_timing_pulse = (phase_q == 4'h1) || (phase_q == 4'h2);
    assign backplane.second_timing_pulse = (phase_q == 4'h6) || (phase_q == 4'h7);
    assign backplane.state_code_bit1 = cur_state[1];
    assign backplane.state_code_bit0 = cur_state[0];
    assign backplane.q_output = pc_q[0];
    assign backplane.addr = (phase_q <= 4'h2) ? cur_addr[15:8] : cur_addr[7:0];
    assign backplane.data = data_w;

    // A machine cycle is ten clocks; a low wait request freezes it where it stands.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n || !clear_request_n)
        begin
            phase_q <= 4'h0;
            st_q <= panel_pkg::STATE_FETCH;
            init_q <= 1'b1;
            idle_q <= 1'b0;
            util_q <= 1'b0;
            pc_q <= 16'h0000;
            dma_ptr_q <= 16'h0000;
            cycle_count <= 16'h0000;
            dma_count <= 16'h0000;
        end
        else if (wait_request_n)
        begin
            phase_q <= (phase_q == 4'h9) ? 4'h0 : phase_q + 4'h1;
            if (init_q && phase_q == 4'h6)
                util_q <= utility_start_request;
            if (phase_q == 4'h9)
            begin
                cycle_count <= cycle_count + 16'h0001;
                if (st_q == panel_pkg::STATE_DMA)
                begin
                    dma_ptr_q <= dma_ptr_q + 16'h0001;
                    dma_count <= dma_count + 16'h0001;
                    idle_q <= 1'b0;
                end
                if (init_q)
                begin
                    init_q <= 1'b0;
                    pc_q <= util_q ? 16'h8000 : 16'h0000;
                end
                else if (!dma_out_request_n)
                    st_q <= panel_pkg::STATE_DMA;
                else if (st_q == panel_pkg::STATE_FETCH)
                begin
                    idle_q <= (data_w == panel_pkg::IDLE_OPCODE);
                    st_q <= panel_pkg::STATE_EXECUTE;
                    pc_q <= pc_q + 16'h0001;
                end
                else if (!idle_q || st_q == panel_pkg::STATE_DMA)
                    st_q <= panel_pkg::STATE_FETCH;
            end
        end
    end
endmodule : cpu_backplane_model
`default_nettype wire

// *** cpu_run_step_control_panel.sv ***
// Function
// - Reset key latches clear, drops wait.
// - Latched clear lights clear, darkens wait.
// - Run-program key removes the clear request.
// - Run-utility also raises utility start request.
// - Continuous runs free; step allows one cycle.
// - Step mode halts between the timing pulses.
// - Wait lamp lit in step, dark stepping.
// - Run key darkens wait and clear lamps.
// - Running lamp from run key until idle/reset.
// - State lamps follow processor state code.
// - Latch high address; show low and data.
// - Digits b and d drawn lower case.
// - Run-program during idle requests DMA out.
// - Idle shows running and clear lamps dark.
// - Every bump DMA unstepped, later cycles stepped.
// - ROM socket selected for 8400 to 87ff.
`timescale 1ns/1ps
`default_nettype none
module cpu_run_step_control_panel #(
    parameter int DEBOUNCE_CYCLES = panel_pkg::DEBOUNCE_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Front panel keys and toggle, high while pressed or in step
    input wire logic reset_key,
    input wire logic run_program_key,
    input wire logic run_utility_key,
    input wire logic step_continuous_toggle,
    // Backplane signals from the processor
    input wire panel_pkg::backplane_type backplane,
    // Backplane requests to the processor
    output logic clear_request_n,
    output logic wait_request_n,
    output logic dma_out_request_n,
    output logic utility_start_request,
    output logic rom_select,
    // Display
    output panel_pkg::indicator_type indicators,
    output logic [6:0] segments [panel_pkg::DIGITS]
);

    // ------------------------------------------------------------------
    // Keys
    // ------------------------------------------------------------------
    logic reset_press;
    logic run_p_press;
    logic run_u_press;
    logic step_mode;
    logic run_press;

    key_debounce #(.CYCLES(DEBOUNCE_CYCLES)) u_reset_key (
        .clk(clk), .rst_n(rst_n), .key_pin(reset_key), .level(), .press(reset_press)
    );

    key_debounce #(.CYCLES(DEBOUNCE_CYCLES)) u_run_program_key (
        .clk(clk), .rst_n(rst_n), .key_pin(run_program_key), .level(), .press(run_p_press)
    );

    key_debounce #(.CYCLES(DEBOUNCE_CYCLES)) u_run_utility_key (
        .clk(clk), .rst_n(rst_n), .key_pin(run_utility_key), .level(), .press(run_u_press)
    );

    key_debounce #(.CYCLES(DEBOUNCE_CYCLES)) u_step_toggle (
        .clk(clk), .rst_n(rst_n), .key_pin(step_continuous_toggle), .level(step_mode), .press()
    );

    assign run_press = run_p_press | run_u_press;

    // ------------------------------------------------------------------
    // Backplane synchroniser and timing edges
    // ------------------------------------------------------------------
    panel_pkg::backplane_type bp_meta_q;
    panel_pkg::backplane_type bp_q;
    logic tpa_prev_q;
    logic tpb_prev_q;
    logic tpa_rise;
    logic tpb_rise;
    logic [1:0] state_code;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bp_meta_q <= '0;
            bp_q <= '0;
        end
        else
        begin
            bp_meta_q <= backplane;
            bp_q <= bp_meta_q;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tpa_prev_q <= 1'b0;
            tpb_prev_q <= 1'b0;
        end
        else
        begin
            tpa_prev_q <= bp_q.first_timing_pulse;
            tpb_prev_q <= bp_q.second_timing_pulse;
        end
    end

    assign tpa_rise = bp_q.first_timing_pulse & ~tpa_prev_q;
    assign tpb_rise = bp_q.second_timing_pulse & ~tpb_prev_q;
    assign state_code = {bp_q.state_code_bit1, bp_q.state_code_bit0};

    // ------------------------------------------------------------------
    // Clear and utility start
    // ------------------------------------------------------------------
    logic clear_q;
    logic utility_q;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            clear_q <= panel_pkg::CLEAR_RESET;
        else if (reset_press)
            clear_q <= 1'b1;
        else if (run_press)
            clear_q <= 1'b0;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            utility_q <= 1'b0;
        else if (reset_press)
            utility_q <= 1'b0;
        else if (run_u_press)
            utility_q <= 1'b1;
        else if (tpb_rise && !clear_q)
            utility_q <= 1'b0;
    end

    // ------------------------------------------------------------------
    // Idle detection and running lamp
    // ------------------------------------------------------------------
    logic idle_q;
    logic idle_set;
    logic running_q;

    assign idle_set = tpb_rise && !clear_q && state_code == panel_pkg::STATE_FETCH
        && bp_q.data == panel_pkg::IDLE_OPCODE;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            idle_q <= 1'b0;
        else if (reset_press || (tpb_rise && state_code == panel_pkg::STATE_DMA))
            idle_q <= 1'b0;
        else if (idle_set)
            idle_q <= 1'b1;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            running_q <= 1'b0;
        else if (reset_press || idle_set)
            running_q <= 1'b0;
        else if (run_press)
            running_q <= 1'b1;
    end

    // ------------------------------------------------------------------
    // Restart from idle by a DMA out request
    // ------------------------------------------------------------------
    logic dma_q;
    logic skip_q;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            dma_q <= 1'b0;
        else if (reset_press)
            dma_q <= 1'b0;
        else if (run_p_press && idle_q)
            dma_q <= 1'b1;
        else if (tpa_rise && state_code == panel_pkg::STATE_DMA)
            dma_q <= 1'b0;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            skip_q <= 1'b0;
        else if (reset_press)
            skip_q <= 1'b0;
        else if (run_p_press && idle_q)
            skip_q <= 1'b1;
        else if (tpb_rise && state_code == panel_pkg::STATE_DMA)
            skip_q <= 1'b0;
    end

    // ------------------------------------------------------------------
    // Single machine-cycle stepping
    // ------------------------------------------------------------------
    logic allow_q;
    logic tpb_seen_q;
    logic wait_on;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            allow_q <= 1'b0;
            tpb_seen_q <= 1'b0;
        end
        else if (run_press)
        begin
            allow_q <= 1'b1;
            tpb_seen_q <= 1'b0;
        end
        else if (allow_q && tpb_rise)
        begin
            tpb_seen_q <= 1'b1;
        end
        else if (allow_q && tpb_seen_q && tpa_rise && !skip_q)
        begin
            allow_q <= 1'b0;
            tpb_seen_q <= 1'b0;
        end
    end

    assign wait_on = step_mode && !clear_q && !allow_q && !skip_q;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            clear_request_n <= 1'b0;
            wait_request_n <= 1'b1;
            dma_out_request_n <= 1'b1;
            utility_start_request <= 1'b0;
        end
        else
        begin
            clear_request_n <= ~clear_q;
            wait_request_n <= ~wait_on;
            dma_out_request_n <= ~dma_q;
            utility_start_request <= utility_q;
        end
    end

    // ------------------------------------------------------------------
    // Address latch, ROM select and display
    // ------------------------------------------------------------------
    logic [7:0] addr_high_q;
    logic [15:0] full_addr;
    logic [23:0] shown;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            addr_high_q <= panel_pkg::ADDR_HIGH_RESET;
        end
        else if (tpa_rise)
        begin
            addr_high_q <= bp_q.addr;
        end
    end

    assign full_addr = {addr_high_q, bp_q.addr};
    assign shown = {full_addr, bp_q.data};

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rom_select <= 1'b0;
        else
            rom_select <= full_addr >= panel_pkg::ROM_FIRST
                && full_addr <= panel_pkg::ROM_LAST;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            indicators <= '0;
        end
        else
        begin
            indicators.running_indicator <= running_q;
            indicators.clear_indicator <= clear_q;
            indicators.wait_indicator <= wait_on;
            indicators.q_indicator <= bp_q.q_output;
            indicators.state_code_bit1 <= bp_q.state_code_bit1;
            indicators.state_code_bit0 <= bp_q.state_code_bit0;
        end
    end

    for (genvar i = 0; i < panel_pkg::DIGITS; i++)
    begin : g_digit
        always_ff @(posedge clk or negedge rst_n)
        begin
            if (!rst_n)
            begin
                segments[i] <= 7'h00;
            end
            else
            begin
                segments[i] <= panel_pkg::hex_to_segments(shown[4*i +: 4]);
            end
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_bump;
        run_p_press && idle_q && !reset_press;
    endsequence

    sequence s_step_end;
        allow_q && tpb_seen_q && tpa_rise && !skip_q && !run_press;
    endsequence

    a_reset_clears: assert property (reset_press |=> ##1 !clear_request_n && wait_request_n)
        else $error("reset key did not clear and drop wait");
    a_clear_lamps: assert property (reset_press |=> ##1 indicators.clear_indicator
        && !indicators.wait_indicator)
        else $error("clear lamps wrong after reset key");
    a_run_release: assert property (run_press && !reset_press |=> ##1 clear_request_n)
        else $error("run key did not release clear");
    a_utility_start: assert property (run_u_press && !reset_press |=> ##1 utility_start_request)
        else $error("utility start not raised");
    a_cont_free: assert property (!step_mode |=> wait_request_n)
        else $error("wait raised in continuous mode");
    a_step_halt: assert property (s_step_end ##1 step_mode && !clear_q |=> !wait_request_n)
        else $error("step did not halt after one cycle");
    a_step_lamp: assert property (run_press && !reset_press |=> ##1 !indicators.wait_indicator)
        else $error("wait lamp lit while stepping");
    a_run_lamp: assert property (run_press && !reset_press && !idle_set |=> ##1 indicators.running_indicator
        && !indicators.clear_indicator)
        else $error("running lamp not lit after run key");
    a_idle_dark: assert property (idle_set |=> ##1 !indicators.running_indicator)
        else $error("running lamp lit at idle");
    a_idle_bump: assert property (s_bump |=> ##1 !dma_out_request_n)
        else $error("no dma request on bump from idle");
    a_bump_free: assert property (s_bump |=> ##1 wait_request_n)
        else $error("bump dma was stepped");
    a_rom_window: assert property (rom_select |-> $past(full_addr[15:10]) == 6'h21)
        else $error("rom selected outside its window");

endmodule : cpu_run_step_control_panel
`default_nettype wire

// *** cpu_run_step_control_panel_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module cpu_run_step_control_panel_tb_top;
    localparam int DB = 4;
    localparam logic [6:0] SEG_TAB [16] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d,
        7'h07, 7'h7f, 7'h6f, 7'h77, 7'h7c, 7'h39, 7'h5e, 7'h79, 7'h71};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] keys = 3'h0;
    logic step_continuous_toggle = 1'b0;
    panel_pkg::backplane_type bp;
    panel_pkg::indicator_type indicators;
    logic [6:0] segments [panel_pkg::DIGITS];
    logic clear_request_n, wait_request_n, dma_out_request_n, utility_start_request, rom_select;
    logic [15:0] cycle_count, dma_count, cur_addr, first_fetch, base_cyc, base_dma;
    logic [1:0] cur_state;
    logic tpa_q = 1'b0;
    logic fetched = 1'b0;
    logic wait_dark_seen = 1'b0;
    logic dma_seen = 1'b0;
    logic util_seen = 1'b0;
    int fail_count = 0;
    int n_compared = 0;
    int seed = 32'h8f41;

    always #2.5 clk = ~clk;

    cpu_run_step_control_panel #(.DEBOUNCE_CYCLES(DB)) i_cpu_run_step_control_panel (
        .clk(clk), .rst_n(rst_n), .reset_key(keys[0]), .run_program_key(keys[1]),
        .run_utility_key(keys[2]), .step_continuous_toggle(step_continuous_toggle),
        .backplane(bp), .clear_request_n(clear_request_n), .wait_request_n(wait_request_n),
        .dma_out_request_n(dma_out_request_n), .utility_start_request(utility_start_request),
        .rom_select(rom_select), .indicators(indicators), .segments(segments));

    cpu_backplane_model i_cpu_backplane_model (
        .clk(clk), .rst_n(rst_n), .clear_request_n(clear_request_n),
        .wait_request_n(wait_request_n), .dma_out_request_n(dma_out_request_n),
        .utility_start_request(utility_start_request), .backplane(bp),
        .cycle_count(cycle_count), .dma_count(dma_count), .cur_addr(cur_addr),
        .cur_state(cur_state));

    // ------------------------------------------------------------------
    // Monitors
    // ------------------------------------------------------------------
    always @(posedge clk)
    begin
        tpa_q <= bp.first_timing_pulse;
        if (indicators.wait_indicator === 1'b0) wait_dark_seen <= 1'b1;
        if (dma_out_request_n === 1'b0) dma_seen <= 1'b1;
        if (utility_start_request === 1'b1) util_seen <= 1'b1;
        if (bp.first_timing_pulse && !tpa_q && cur_state == panel_pkg::STATE_FETCH && !fetched)
        begin
            first_fetch <= cur_addr;
            fetched <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] expected, input logic [15:0] seen);
        n_compared++;
        if (seen !== expected)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, expected, seen);
        end
    endtask : check

    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : final_report

    task automatic press(input int which);
        int hold;
        hold = DB + 8 + ($unsigned($random(seed)) % 8);
        @(negedge clk);
        wait_dark_seen = 1'b0;
        keys = 3'h1 << which;
        repeat (hold) @(negedge clk);
        keys = 3'h0;
        repeat (40) @(negedge clk);
    endtask : press

    task automatic check_halt();
        logic [23:0] v;
        v = {cur_addr, bp.data};
        check("pulses", 16'h0000, 16'({bp.first_timing_pulse, bp.second_timing_pulse}));
        check("wait_req", 16'h0000, 16'(wait_request_n));
        check("wait_lamp", 16'h0001, 16'(indicators.wait_indicator));
        check("wait_dark", 16'h0001, 16'(wait_dark_seen));
        check("state_lamps", 16'({bp.q_output, cur_state}), 16'(indicators[2:0]));
        check("rom", 16'((cur_addr >= 16'h8400) && (cur_addr <= 16'h87ff)), 16'(rom_select));
        for (int i = 0; i < panel_pkg::DIGITS; i++)
            check("segments", 16'(SEG_TAB[v[4*i +: 4]]), 16'(segments[i]));
    endtask : check_halt

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        fork
            begin
                #100000;
                fail_count++;
                $display("mismatch watchdog expected finish seen timeout");
                final_report();
            end
        join_none
        @(negedge clk);
        check("clear_req_rst", 16'h0000, 16'(clear_request_n));
        check("wait_req_rst", 16'h0001, 16'(wait_request_n));
        @(negedge clk);
        rst_n = 1'b1;
        keys = 3'h2;
        repeat (2) @(negedge clk);
        keys = 3'h0;
        repeat (20) @(negedge clk);
        check("clear_bounce", 16'h0000, 16'(clear_request_n));
        check("lamps_rst", 16'h0002, 16'(indicators[5:3]));
        press(1);
        check("clear_req_run", 16'h0001, 16'(clear_request_n));
        check("lamps_run", 16'h0004, 16'(indicators[5:3]));
        repeat (200) @(negedge clk);
        check("lamps_idle", 16'h0000, 16'(indicators[5:3]));
        check("first_fetch", 16'h0000, first_fetch);
        base_dma = dma_count;
        fetched = 1'b0;
        press(1);
        check("dma_req", 16'h0001, 16'(dma_seen));
        check("dma_cycles", base_dma + 16'h0001, dma_count);
        check("fetch_after_dma", 16'h0007, first_fetch);
        check("lamps_bump", 16'h0004, 16'(indicators[5:3]));
        press(0);
        check("clear_req_key", 16'h0000, 16'(clear_request_n));
        check("wait_req_key", 16'h0001, 16'(wait_request_n));
        check("lamps_reset", 16'h0002, 16'(indicators[5:3]));
        fetched = 1'b0;
        press(2);
        check("util_req", 16'h0001, 16'(util_seen));
        check("util_fetch", 16'h8000, first_fetch);
        check("lamps_util", 16'h0004, 16'(indicators[5:3]));
        press(0);
        step_continuous_toggle = 1'b1;
        repeat (20) @(negedge clk);
        for (int n = 0; n < 14; n++)
        begin
            base_cyc = cycle_count;
            press(1);
            check("step_cycles", base_cyc + 16'h0001, cycle_count);
            check_halt();
        end
        check("lamps_step_idle", 16'h0001, 16'(indicators[5:3]));
        base_cyc = cycle_count;
        base_dma = dma_count;
        fetched = 1'b0;
        press(1);
        check("bump_cycles", base_cyc + 16'h0002, cycle_count);
        check("bump_dma", base_dma + 16'h0001, dma_count);
        check("bump_fetch", 16'h0007, first_fetch);
        check_halt();
        base_cyc = cycle_count;
        press(1);
        check("step_after_dma", base_cyc + 16'h0001, cycle_count);
        final_report();
    end
endmodule : cpu_run_step_control_panel_tb_top
`default_nettype wire

// *** key_debounce.sv ***
`timescale 1ns/1ps
`default_nettype none
module key_debounce #(
    parameter int CYCLES = panel_pkg::DEBOUNCE_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Raw key pin, high while pressed
    input wire logic key_pin,
    // Debounced level and press pulse
    output logic level,
    output logic press
);
    localparam int CW = $clog2(CYCLES + 1);

    logic sync1_q;
    logic sync2_q;
    logic level_q;
    logic press_q;
    logic [CW-1:0] count_q;

    // ------------------------------------------------------------------
    // Two-stage synchroniser
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end
        else
        begin
            sync1_q <= key_pin;
            sync2_q <= sync1_q;
        end
    end

    // ------------------------------------------------------------------
    // Settle counter, one press pulse per clean closure
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count_q <= '0;
            level_q <= 1'b0;
            press_q <= 1'b0;
        end
        else
        begin
            press_q <= 1'b0;
            if (sync2_q == level_q)
            begin
                count_q <= '0;
            end
            else if (count_q == CW'(CYCLES - 1))
            begin
                count_q <= '0;
                level_q <= sync2_q;
                press_q <= sync2_q;
            end
            else
            begin
                count_q <= count_q + 1'b1;
            end
        end
    end

    assign level = level_q;
    assign press = press_q;
endmodule : key_debounce
`default_nettype wire

// *** panel_pkg.sv ***
package panel_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    // Clock rate in MHz.
    localparam int CLK_MHZ = 200;
    // Debounce settle time in microseconds.
    localparam int DEBOUNCE_US = 5000;
    // Debounce settle time in clock cycles.
    localparam int DEBOUNCE_CYCLES = DEBOUNCE_US * CLK_MHZ;

    // ------------------------------------------------------------------
    // Processor codes and addresses
    // ------------------------------------------------------------------
    localparam logic [1:0] STATE_FETCH = 2'h0;
    localparam logic [1:0] STATE_EXECUTE = 2'h1;
    localparam logic [1:0] STATE_DMA = 2'h2;
    localparam logic [7:0] IDLE_OPCODE = 8'h00;
    localparam logic [15:0] ROM_FIRST = 16'h8400;
    localparam logic [15:0] ROM_LAST = 16'h87ff;
    localparam int DIGITS = 6;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic CLEAR_RESET = 1'b1;
    localparam logic [7:0] ADDR_HIGH_RESET = 8'h00;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic first_timing_pulse;
        logic second_timing_pulse;
        logic state_code_bit1;
        logic state_code_bit0;
        logic q_output;
        logic [7:0] addr;
        logic [7:0] data;
    } backplane_type;

    typedef struct packed {
        logic running_indicator;
        logic clear_indicator;
        logic wait_indicator;
        logic q_indicator;
        logic state_code_bit1;
        logic state_code_bit0;
    } indicator_type;

    // ------------------------------------------------------------------
    // Hex to seven segments, bit 6 is g down to bit 0 is a
    // ------------------------------------------------------------------
    function automatic logic [6:0] hex_to_segments(input logic [3:0] nibble);
        logic [6:0] seg;
        case (nibble)
            4'h0: seg = 7'h3f;
            4'h1: seg = 7'h06;
            4'h2: seg = 7'h5b;
            4'h3: seg = 7'h4f;
            4'h4: seg = 7'h66;
            4'h5: seg = 7'h6d;
            4'h6: seg = 7'h7d;
            4'h7: seg = 7'h07;
            4'h8: seg = 7'h7f;
            4'h9: seg = 7'h6f;
            4'ha: seg = 7'h77;
            4'hb: seg = 7'h7c;
            4'hc: seg = 7'h39;
            4'hd: seg = 7'h5e;
            4'he: seg = 7'h79;
            default: seg = 7'h71;
        endcase
        return seg;
    endfunction : hex_to_segments

endpackage : panel_pkg
